// *** common/pfp_defs.vh ***
// Constants and register map of the per-port forwarding policy block
// Operation
// [R1] Drop mode 00: never drop, flow control
// [R2] Drop mode 01: drop priority 0 frames
// [R3] Drop mode 10: drop priority 0, 1
// [R4] Drop mode 11: drop priority 0, 1, 2
// [R5] Seven-bit membership mask, bit 0 port 1
// [R6] Set bit forwards, clear blocks, reset all set
// [R7] Membership mask ignores VLAN tags and table
// [R8] Null VID bit set: look up VID zero
// [R9] Null VID bit clear: look up default VID
// [R10] Ingress filtering drops non-member ingress frames
// [R11] Non-default VID discard drops mismatching VIDs
// [R12] MAC-based 802.1X enable drives lookup authentication
// [R13] Self-address filter drops own source MAC
// [R14] Self filter needs port and global enable
// [R15] Independent policy copy for ports one to six
// [R16] Congestion per destination comes from queue manager
// [R17] Priorities 0 to 2 are the lowest
`ifndef PFP_DEFS_VH
`define PFP_DEFS_VH

// Per-port page offsets, port number in address bits 15:12
`define PFP_OFF_DROP 12'hA00
`define PFP_OFF_MASK 12'hA04
`define PFP_OFF_LKUP 12'hB00
`define PFP_OFF_PORT_DEFAULT_VLAN_ID 12'hB08
`define PFP_OFF_DCNT 12'hB0C
// Global registers in page 0
`define PFP_OFF_GCTL 12'h300
`define PFP_OFF_MACL 12'h304
`define PFP_OFF_MACH 12'h308

// Register selectors inside one port copy
`define PFP_SEL_DROP 3'h0
`define PFP_SEL_MASK 3'h1
`define PFP_SEL_LKUP 3'h2
`define PFP_SEL_PORT_DEFAULT_VLAN_ID 3'h3
`define PFP_SEL_DCNT 3'h4

// Reset values
`define PFP_DROP_RST 2'h0
`define PFP_MASK_RST 7'h7F
`define PFP_LKUP_RST 8'h00
`define PFP_PORT_DEFAULT_VLAN_ID_RST 12'h001
`define PFP_LKUP_WMASK 8'hFA

// Lookup control field positions
`define PFP_LK_NULLVID 7
`define PFP_LK_INFILT 6
`define PFP_LK_NONPVID 5
`define PFP_LK_MAC1X 4
`define PFP_LK_SELF 3
`define PFP_GCTL_SELF 0

// Drop modes
`define PFP_DM_NODROP 2'h0
`define PFP_DM_P0 2'h1
`define PFP_DM_P01 2'h2
`define PFP_DM_P012 2'h3

// Discard reason bits
`define PFP_RSN_INFILT 0
`define PFP_RSN_NONPVID 1
`define PFP_RSN_SELF 2
`define PFP_RSN_CONG 3
`define PFP_RSN_NOFWD 4

`endif

// *** hw/pfp_policy.v ***
// Ingress forwarding policy for switch ports 1 to 6 with APB registers
`timescale 1ns/1ps
`include "pfp_defs.vh"

module pfp_policy #(
    parameter NPORT = 6,
    parameter CNT_W = 16
) (
    // Clock and reset
    input wire REF_CLK_I,
    input wire SRST_I,
    // APB slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [15:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    // Frame from lookup engine
    input wire FRM_VALID_I,
    input wire [2:0] FRM_PORT_I,
    input wire FRM_TAGGED_I,
    input wire [11:0] FRM_VID_I,
    input wire [1:0] FRM_PRIO_I,
    input wire [47:0] FRM_SA_I,
    input wire [6:0] FRM_DST_I,
    // VLAN table lookup
    output reg VLT_REQ_O,
    output reg [11:0] VLT_VID_O,
    input wire [6:0] VLT_MEMBER_I,
    // Congestion per destination port
    input wire [6:0] CONG_I,
    // Verdict
    output reg RES_VALID_O,
    output reg RES_DISCARD_O,
    output reg [6:0] RES_FWD_O,
    output reg RES_MAC_AUTH_O,
    output reg [4:0] RES_REASON_O,
    // Flow control toward ingress ports
    output reg [5:0] FC_O
);

    // Global registers
    reg gself_r;
    reg [47:0] mac_r;

    // APB decode
    wire [3:0] a_port = PADDR_I[15:12];
    wire [11:0] a_off = PADDR_I[11:0];
    wire setup = PSEL_I && !PENABLE_I;
    wire acc_done = PSEL_I && PENABLE_I && PREADY_O;
    reg a_glob;
    reg a_pmap;
    reg [2:0] a_sel;

    always @* begin
        a_glob = 1'b0;
        a_pmap = 1'b1;
        a_sel = `PFP_SEL_DROP;
        case (a_off)
            `PFP_OFF_DROP: a_sel = `PFP_SEL_DROP;
            `PFP_OFF_MASK: a_sel = `PFP_SEL_MASK;
            `PFP_OFF_LKUP: a_sel = `PFP_SEL_LKUP;
            `PFP_OFF_PORT_DEFAULT_VLAN_ID: a_sel = `PFP_SEL_PORT_DEFAULT_VLAN_ID;
            `PFP_OFF_DCNT: a_sel = `PFP_SEL_DCNT;
            default: a_pmap = 1'b0;
        endcase
        if (a_port == 4'h0) begin
            a_pmap = 1'b0;
            a_glob = (a_off == `PFP_OFF_GCTL) || (a_off == `PFP_OFF_MACL) ||
                (a_off == `PFP_OFF_MACH);
        end else if (a_port > NPORT) begin
            a_pmap = 1'b0;
        end
    end

    wire mapped = a_glob || a_pmap;
    wire wr_acc = acc_done && PWRITE_I && mapped;

    // Port copies
    wire [NPORT*32-1:0] p_rdata;
    wire [NPORT*2-1:0] p_drop;
    wire [NPORT*7-1:0] p_mask;
    wire [NPORT*8-1:0] p_lkup;
    wire [NPORT*12-1:0] p_port_default_vlan_id;
    reg [NPORT-1:0] drop_evt;

    genvar g;
    generate
        for (g = 0; g < NPORT; g = g + 1) begin : g_port
            pfp_port_ctl #(
                .CNT_W(CNT_W)
            ) u_ctl (
                .clk_i(REF_CLK_I),
                .srst_i(SRST_I),
                .wr_i(wr_acc && a_pmap && (a_port == g + 1)),
                .sel_i(a_sel),
                .wdata_i(PWDATA_I),
                .rdata_o(p_rdata[g*32 +: 32]),
                .drop_evt_i(drop_evt[g]),
                .drop_mode_o(p_drop[g*2 +: 2]),
                .mask_o(p_mask[g*7 +: 7]),
                .lkup_o(p_lkup[g*8 +: 8]),
                .port_default_vlan_id_o(p_port_default_vlan_id[g*12 +: 12])
            ); // R15
        end
    endgenerate

    // Read data
    reg [31:0] rd_nxt;
    integer i;
    integer i_f;
    integer i_ev;
    integer i_fc;

    always @* begin
        rd_nxt = 32'h0000_0000;
        if (a_glob) begin
            if (a_off == `PFP_OFF_GCTL) begin
                rd_nxt[`PFP_GCTL_SELF] = gself_r;
            end else if (a_off == `PFP_OFF_MACL) begin
                rd_nxt = mac_r[31:0];
            end else begin
                rd_nxt[15:0] = mac_r[47:32];
            end
        end else if (a_pmap) begin
            for (i = 0; i < NPORT; i = i + 1) begin
                if (a_port == i + 1) begin
                    rd_nxt = p_rdata[i*32 +: 32];
                end
            end
        end
    end

    // Zero-wait slave: ready in every access phase
    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
            gself_r <= 1'b0;
            mac_r <= 48'h0000_0000_0000;
        end else begin
            PREADY_O <= setup;
            if (setup) begin
                PSLVERR_O <= !mapped;
                PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_nxt;
            end
            if (wr_acc && a_glob) begin
                if (a_off == `PFP_OFF_GCTL) begin
                    gself_r <= PWDATA_I[`PFP_GCTL_SELF];
                end else if (a_off == `PFP_OFF_MACL) begin
                    mac_r[31:0] <= PWDATA_I;
                end else begin
                    mac_r[47:32] <= PWDATA_I[15:0];
                end
            end
        end
    end

    // Stage 1: classify the frame and fetch its port's policy
    reg [1:0] f_drop;
    reg [6:0] f_mask;
    reg [7:0] f_lkup;
    reg [11:0] f_port_default_vlan_id;
    reg f_ok;
    reg [11:0] f_vid;

    always @* begin
        f_drop = `PFP_DM_NODROP;
        f_mask = 7'h00;
        f_lkup = 8'h00;
        f_port_default_vlan_id = 12'h000;
        f_ok = 1'b0;
        for (i_f = 0; i_f < NPORT; i_f = i_f + 1) begin
            if (FRM_PORT_I == i_f + 1) begin
                f_ok = 1'b1;
                f_drop = p_drop[i_f*2 +: 2];
                f_mask = p_mask[i_f*7 +: 7];
                f_lkup = p_lkup[i_f*8 +: 8];
                f_port_default_vlan_id = p_port_default_vlan_id[i_f*12 +: 12];
            end
        end
        if (!FRM_TAGGED_I) begin
            f_vid = f_port_default_vlan_id;
        end else if (FRM_VID_I == 12'h000) begin
            // R8 R9
            f_vid = f_lkup[`PFP_LK_NULLVID] ? 12'h000 : f_port_default_vlan_id;
        end else begin
            f_vid = FRM_VID_I;
        end
    end

    reg s1_v_r;
    reg [2:0] s1_port_r;
    reg [1:0] s1_prio_r;
    reg [6:0] s1_dst_r;
    reg [6:0] s1_mask_r;
    reg [1:0] s1_drop_r;
    reg [7:0] s1_lkup_r;
    reg [11:0] s1_port_default_vlan_id_r;
    reg s1_self_r;

    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            s1_v_r <= 1'b0;
            s1_port_r <= 3'h0;
            s1_prio_r <= 2'h0;
            s1_dst_r <= 7'h00;
            s1_mask_r <= 7'h00;
            s1_drop_r <= 2'h0;
            s1_lkup_r <= 8'h00;
            s1_port_default_vlan_id_r <= 12'h000;
            s1_self_r <= 1'b0;
            VLT_REQ_O <= 1'b0;
            VLT_VID_O <= 12'h000;
        end else begin
            s1_v_r <= FRM_VALID_I && f_ok;
            VLT_REQ_O <= FRM_VALID_I && f_ok;
            if (FRM_VALID_I) begin
                s1_port_r <= FRM_PORT_I;
                s1_prio_r <= FRM_PRIO_I;
                s1_dst_r <= FRM_DST_I;
                s1_mask_r <= f_mask;
                s1_drop_r <= f_drop;
                s1_lkup_r <= f_lkup;
                s1_port_default_vlan_id_r <= f_port_default_vlan_id;
                VLT_VID_O <= f_vid;
                // R13 R14
                s1_self_r <= gself_r && f_lkup[`PFP_LK_SELF] &&
                    (FRM_SA_I == mac_r);
            end
        end
    end

    // Stage 2: verdict, using the VLAN table answer of this cycle
    reg [6:0] ing_bit;
    reg lowpri;
    reg [6:0] cong_cut;
    reg [6:0] fwd_nxt;
    reg [4:0] rsn_nxt;

    always @* begin
        ing_bit = 7'h01 << (s1_port_r - 3'h1);
        case (s1_drop_r)
            `PFP_DM_P0: lowpri = (s1_prio_r == 2'h0); // R2 R17
            `PFP_DM_P01: lowpri = (s1_prio_r <= 2'h1); // R3
            `PFP_DM_P012: lowpri = (s1_prio_r <= 2'h2); // R4
            default: lowpri = 1'b0; // R1
        endcase
        cong_cut = lowpri ? (CONG_I & s1_dst_r) : 7'h00; // R16
        fwd_nxt = s1_dst_r & s1_mask_r & ~cong_cut; // R5 R6 R7
        rsn_nxt = 5'h00;
        rsn_nxt[`PFP_RSN_INFILT] = s1_lkup_r[`PFP_LK_INFILT] &&
            ((VLT_MEMBER_I & ing_bit) == 7'h00); // R10
        rsn_nxt[`PFP_RSN_NONPVID] = s1_lkup_r[`PFP_LK_NONPVID] &&
            (VLT_VID_O != s1_port_default_vlan_id_r); // R11
        rsn_nxt[`PFP_RSN_SELF] = s1_self_r; // R13
        rsn_nxt[`PFP_RSN_CONG] = (cong_cut != 7'h00);
        rsn_nxt[`PFP_RSN_NOFWD] = (fwd_nxt == 7'h00);
    end

    wire disc_nxt = (rsn_nxt[`PFP_RSN_INFILT] || rsn_nxt[`PFP_RSN_NONPVID] ||
        rsn_nxt[`PFP_RSN_SELF] || rsn_nxt[`PFP_RSN_NOFWD]);

    always @* begin
        for (i_ev = 0; i_ev < NPORT; i_ev = i_ev + 1) begin
            drop_evt[i_ev] = s1_v_r && disc_nxt && (s1_port_r == i_ev + 1);
        end
    end

    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            RES_VALID_O <= 1'b0;
            RES_DISCARD_O <= 1'b0;
            RES_FWD_O <= 7'h00;
            RES_MAC_AUTH_O <= 1'b0;
            RES_REASON_O <= 5'h00;
        end else begin
            RES_VALID_O <= s1_v_r;
            if (s1_v_r) begin
                RES_DISCARD_O <= disc_nxt;
                RES_FWD_O <= disc_nxt ? 7'h00 : fwd_nxt;
                RES_MAC_AUTH_O <= s1_lkup_r[`PFP_LK_MAC1X]; // R12
                RES_REASON_O <= rsn_nxt;
            end
        end
    end

    // Flow control only in no-drop mode, while a reachable port congests
    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            FC_O <= 6'h00;
        end else begin
            for (i_fc = 0; i_fc < NPORT; i_fc = i_fc + 1) begin
                FC_O[i_fc] <= (p_drop[i_fc*2 +: 2] == `PFP_DM_NODROP) &&
                    ((CONG_I & p_mask[i_fc*7 +: 7]) != 7'h00); // R1 R16
            end
        end
    end

endmodule // pfp_policy

// *** hw/pfp_port_ctl.v ***
// One port's policy registers and its discard counter
`timescale 1ns/1ps
`include "pfp_defs.vh"

module pfp_port_ctl #(
    parameter CNT_W = 16
) (
    // Clock and reset
    input wire clk_i,
    input wire srst_i,
    // Register access
    input wire wr_i,
    input wire [2:0] sel_i,
    input wire [31:0] wdata_i,
    output reg [31:0] rdata_o,
    // Events
    input wire drop_evt_i,
    // Policy fields
    output wire [1:0] drop_mode_o,
    output wire [6:0] mask_o,
    output wire [7:0] lkup_o,
    output wire [11:0] port_default_vlan_id_o
);

    reg [1:0] drop_r;
    reg [6:0] mask_r;
    reg [7:0] lkup_r;
    reg [11:0] port_default_vlan_id_r;
    reg [CNT_W-1:0] dcnt_r;

    always @(posedge clk_i) begin
        if (srst_i) begin
            drop_r <= `PFP_DROP_RST;
            mask_r <= `PFP_MASK_RST; // R6
            lkup_r <= `PFP_LKUP_RST;
            port_default_vlan_id_r <= `PFP_PORT_DEFAULT_VLAN_ID_RST;
            dcnt_r <= {CNT_W{1'b0}};
        end else begin
            if (wr_i && sel_i == `PFP_SEL_DROP) begin
                drop_r <= wdata_i[1:0];
            end
            if (wr_i && sel_i == `PFP_SEL_MASK) begin
                mask_r <= wdata_i[6:0]; // R5
            end
            if (wr_i && sel_i == `PFP_SEL_LKUP) begin
                lkup_r <= wdata_i[7:0] & `PFP_LKUP_WMASK;
            end
            if (wr_i && sel_i == `PFP_SEL_PORT_DEFAULT_VLAN_ID) begin
                port_default_vlan_id_r <= wdata_i[11:0];
            end
            // Count saturates; a write clears, a same-cycle event wins
            if (drop_evt_i) begin
                if (dcnt_r != {CNT_W{1'b1}}) begin
                    dcnt_r <= dcnt_r + 1'b1;
                end
            end else if (wr_i && sel_i == `PFP_SEL_DCNT) begin
                dcnt_r <= {CNT_W{1'b0}};
            end
        end
    end

    always @* begin
        rdata_o = 32'h0000_0000;
        case (sel_i)
            `PFP_SEL_DROP: rdata_o[1:0] = drop_r;
            `PFP_SEL_MASK: rdata_o[6:0] = mask_r;
            `PFP_SEL_LKUP: rdata_o[7:0] = lkup_r;
            `PFP_SEL_PORT_DEFAULT_VLAN_ID: rdata_o[11:0] = port_default_vlan_id_r;
            `PFP_SEL_DCNT: rdata_o[CNT_W-1:0] = dcnt_r;
            default: rdata_o = 32'h0000_0000;
        endcase
    end

    assign drop_mode_o = drop_r;
    assign mask_o = mask_r;
    assign lkup_o = lkup_r;
    assign port_default_vlan_id_o = port_default_vlan_id_r;

endmodule // pfp_port_ctl

// *** sim/pfp_policy_checker.sv ***
// Port assertions of the forwarding policy block
`timescale 1ns/1ps
module pfp_policy_chk (
    // Clock, reset and bus
    input wire REF_CLK_I,
    input wire SRST_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PREADY_O,
    // Frame path
    input wire FRM_VALID_I,
    input wire [2:0] FRM_PORT_I,
    input wire FRM_TAGGED_I,
    input wire [11:0] FRM_VID_I,
    input wire [1:0] FRM_PRIO_I,
    input wire [6:0] FRM_DST_I,
    input wire [6:0] CONG_I,
    input wire VLT_REQ_O,
    input wire [11:0] VLT_VID_O,
    input wire RES_VALID_O,
    input wire RES_DISCARD_O,
    input wire [6:0] RES_FWD_O,
    input wire [4:0] RES_REASON_O,
    input wire [5:0] FC_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SRST_I);
    wire take = FRM_VALID_I && FRM_PORT_I != 3'h0 && FRM_PORT_I != 3'h7;
    property p_rdy;
        PSEL_I && !PENABLE_I |=> PREADY_O;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_pipe;
        take |=> VLT_REQ_O ##1 RES_VALID_O;
    endproperty
    a_pipe: assert property (p_pipe) else $error("no verdict");
    property p_vid;
        take && FRM_TAGGED_I && FRM_VID_I != 12'h000
            |=> VLT_VID_O == $past(FRM_VID_I);
    endproperty
    a_vid: assert property (p_vid) else $error("bad lookup vid");
    property p_fwd;
        RES_VALID_O |-> (RES_FWD_O & ~$past(FRM_DST_I, 2)) == 7'h00;
    endproperty
    a_fwd: assert property (p_fwd) else $error("extra port");
    property p_disc;
        RES_VALID_O && RES_DISCARD_O |-> RES_FWD_O == 7'h00;
    endproperty
    a_disc: assert property (p_disc) else $error("discard fwd");
    property p_prio;
        RES_VALID_O && $past(FRM_PRIO_I, 2) == 2'h3 |-> !RES_REASON_O[3];
    endproperty
    a_prio: assert property (p_prio) else $error("top prio cut");
    property p_self;
        RES_VALID_O && RES_REASON_O[2] |-> RES_DISCARD_O;
    endproperty
    a_self: assert property (p_self) else $error("self kept");
    property p_fc;
        FC_O != 6'h00 |-> $past(CONG_I) != 7'h00;
    endproperty
    a_fc: assert property (p_fc) else $error("fc no cong");
    c_disc: cover property (RES_VALID_O && RES_DISCARD_O);
    c_cong: cover property (RES_VALID_O && RES_REASON_O[3]);
    c_fc: cover property (FC_O != 6'h00);
endmodule // pfp_policy_chk

// *** sim/tb.sv ***
// Self-checking bench of the forwarding policy block
`timescale 1ns/1ps
`include "pfp_defs.vh"
module tb;
    reg clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    reg [15:0] pa = 16'h0000;
    reg [31:0] pwd = 32'h0, lf = 32'hE7DC3F35, q, r, r2;
    reg fv = 1'b0, ft = 1'b0, gs = 1'b0, e;
    reg [2:0] fp = 3'h0, p;
    reg [11:0] fvid = 12'h000;
    reg [1:0] fpr = 2'h0;
    reg [47:0] fsa = 48'h0, mac = 48'h0A0B0C0D0E0F;
    reg [6:0] fd = 7'h00, vm = 7'h00, cg = 7'h00;
    reg [1:0] mode [1:6];
    reg [6:0] mask [1:6];
    reg [7:0] lk [1:6];
    reg [11:0] port_default_vlan_id [1:6];
    reg [19:0] xw;
    reg [15:0] dc [1:6];
    integer n_fail = 0, comparisons = 0, i;
    wire [31:0] prd;
    wire prdy, perr, vreq, rv, rdis, rauth;
    wire [11:0] vvid;
    wire [6:0] rfwd;
    wire [4:0] rrsn;
    wire [5:0] fc;
    always #12.5 clk = ~clk;
    pfp_policy pfp_policy_i (.REF_CLK_I(clk), .SRST_I(srst),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa),
        .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
        .FRM_VALID_I(fv), .FRM_PORT_I(fp), .FRM_TAGGED_I(ft),
        .FRM_VID_I(fvid), .FRM_PRIO_I(fpr), .FRM_SA_I(fsa), .FRM_DST_I(fd),
        .VLT_REQ_O(vreq), .VLT_VID_O(vvid), .VLT_MEMBER_I(vm), .CONG_I(cg),
        .RES_VALID_O(rv), .RES_DISCARD_O(rdis), .RES_FWD_O(rfwd),
        .RES_MAC_AUTH_O(rauth), .RES_REASON_O(rrsn), .FC_O(fc));
    function [31:0] rn(input x);
        begin
            lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
            rn = lf;
        end
    endfunction
    function [15:0] ad(input [2:0] n, input [11:0] o);
        ad = {1'b0, n, o};
    endfunction
    // Lookup vid, discard, forward set
    function [19:0] xv(input [2:0] n, input t, input [11:0] v,
        input [1:0] pr, input [47:0] sa, input [6:0] d, m, c);
        reg [11:0] l;
        reg [6:0] f;
        reg x;
        begin
            l = (!t || (v == 12'h000 && !lk[n][7])) ? port_default_vlan_id[n] : v;
            f = (mode[n] != 2'h0 && pr < mode[n]) ? c & d : 7'h00;
            f = d & mask[n] & ~f;
            x = (lk[n][6] && !m[n - 3'h1]) || (lk[n][5] && l != port_default_vlan_id[n])
                || (gs && lk[n][3] && sa == mac) || f == 7'h00;
            xv = {l, x, x ? 7'h00 : f};
        end
    endfunction
    // Expected discard reasons
    function [4:0] xr(input [2:0] n, input t, input [11:0] v,
        input [1:0] pr, input [47:0] sa, input [6:0] d, m, c);
        reg [11:0] l;
        reg [6:0] f;
        begin
            l = (!t || (v == 12'h000 && !lk[n][7])) ? port_default_vlan_id[n] : v;
            f = (mode[n] != 2'h0 && pr < mode[n]) ? c & d : 7'h00;
            xr = {(d & mask[n] & ~f) == 7'h00, f != 7'h00,
                gs && lk[n][3] && sa == mac, lk[n][5] && l != port_default_vlan_id[n],
                lk[n][6] && !m[n - 3'h1]};
        end
    endfunction
    function [5:0] xfc(input [6:0] c);
        integer k;
        for (k = 1; k <= 6; k = k + 1)
            xfc[k - 1] = mode[k] == 2'h0 && (c & mask[k]) != 7'h00;
    endfunction
    task cmp(input [31:0] g, input [31:0] x);
        begin
            comparisons = comparisons + 1;
            if (g !== x) begin
                n_fail = n_fail + 1;
                $display("Error %0t got %h want %h", $time, g, x);
            end
        end
    endtask
    task stop_test;
        begin
            $display("compares %0d mismatches %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task apb(input w, input [15:0] a, input [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pen <= 1'b0;
            pwr <= w;
            pa <= a;
            pwd <= d;
            @(posedge clk);
            pen <= 1'b1;
            @(posedge clk);
            while (prdy !== 1'b1)
                @(posedge clk);
            q = prd;
            e = perr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    task rd(input [15:0] a, input [31:0] x, input xe);
        begin
            apb(1'b0, a, 32'h0);
            cmp(q, x);
            cmp({31'h0, e}, {31'h0, xe});
        end
    endtask
    task cfg(input [2:0] n, input [1:0] md, input [6:0] mk, input [7:0] l,
        input [11:0] pv);
        begin
            apb(1'b1, ad(n, `PFP_OFF_DROP), {30'h0, md});
            apb(1'b1, ad(n, `PFP_OFF_MASK), {25'h0, mk});
            apb(1'b1, ad(n, `PFP_OFF_LKUP), {24'h0, l});
            apb(1'b1, ad(n, `PFP_OFF_PORT_DEFAULT_VLAN_ID), {20'h0, pv});
            mode[n] = md;
            mask[n] = mk;
            lk[n] = l & `PFP_LKUP_WMASK;
            port_default_vlan_id[n] = pv;
        end
    endtask
    task frm(input [2:0] n, input t, input [11:0] v, input [1:0] pr,
        input [47:0] sa, input [6:0] d, m, c);
        begin
            @(posedge clk);
            fv <= 1'b1;
            fp <= n;
            ft <= t;
            fvid <= v;
            fpr <= pr;
            fsa <= sa;
            fd <= d;
            vm <= m;
            cg <= c;
            @(posedge clk);
            fv <= 1'b0;
            @(posedge clk);
            #1;
            cmp({26'h0, fc}, {26'h0, xfc(c)});
            if (n == 3'h0 || n == 3'h7)
                cmp({31'h0, rv}, 32'h0);
            else begin
                xw = xv(n, t, v, pr, sa, d, m, c);
                dc[n] = dc[n] + {15'h0000, xw[7]};
                cmp({10'h0, rv, rauth, vvid, rdis, rfwd},
                    {10'h0, 1'b1, lk[n][4], xw});
                cmp({27'h0, rrsn},
                    {27'h0, xr(n, t, v, pr, sa, d, m, c)});
            end
        end
    endtask
    initial begin
        #(25 * 20000);
        n_fail = n_fail + 1;
        stop_test;
    end
    initial begin
        for (i = 1; i <= 6; i = i + 1) begin
            mode[i] = 2'h0;
            mask[i] = 7'h7F;
            lk[i] = 8'h00;
            port_default_vlan_id[i] = 12'h001;
            dc[i] = 16'h0000;
        end
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        for (i = 1; i <= 6; i = i + 1) begin
            p = i[2:0];
            rd(ad(p, `PFP_OFF_DROP), 32'h0, 1'b0);
            rd(ad(p, `PFP_OFF_MASK), 32'h7F, 1'b0);
            rd(ad(p, `PFP_OFF_LKUP), 32'h0, 1'b0);
        end
        rd(16'h7A00, 32'h0, 1'b1);
        apb(1'b1, ad(3'h2, `PFP_OFF_LKUP), 32'hFFFFFFFF);
        rd(ad(3'h2, `PFP_OFF_LKUP), 32'hFA, 1'b0);
        apb(1'b1, ad(3'h2, `PFP_OFF_MASK), 32'hFFFFFF80);
        rd(ad(3'h2, `PFP_OFF_MASK), 32'h0, 1'b0);
        rd(ad(3'h5, `PFP_OFF_MASK), 32'h7F, 1'b0);
        cfg(3'h2, 2'h0, 7'h7F, 8'h00, 12'h001);
        $display("test registers done");
        apb(1'b1, 16'h0304, mac[31:0]);
        apb(1'b1, 16'h0308, {16'h0, mac[47:32]});
        for (i = 0; i < 16; i = i + 1) begin
            cfg(3'h3, i[3:2], 7'h7F, 8'h00, 12'h001);
            frm(3'h3, 1'b0, 12'h0, i[1:0], 48'h0, 7'h3F, 7'h7F, 7'h2A);
        end
        cfg(3'h4, 2'h0, 7'h00, 8'h00, 12'h001);
        frm(3'h4, 1'b0, 12'h0, 2'h3, 48'h0, 7'h7F, 7'h7F, 7'h00);
        $display("test drop modes done");
        for (i = 0; i < 150; i = i + 1) begin
            r = rn(1'b0);
            p = 3'h1 + 3'(r[7:0] % 8'h06);
            cfg(p, r[9:8], r[16:10], r[24:17], {9'h000, r[27:25]});
            apb(1'b1, 16'h0300, {31'h0, r[31]});
            gs = r[31];
            r2 = rn(1'b0);
            frm(r2[31:30] == 2'h0 ? {3{r2[0]}} : p, r2[0],
                r2[2:1] == 2'h0 ? 12'h000 : {9'h000, r2[5:3]}, r2[7:6],
                r2[8] ? mac : {16'h0, rn(1'b0)}, r2[15:9], r2[22:16],
                r2[29:23]);
        end
        for (i = 1; i <= 6; i = i + 1) begin
            p = i[2:0];
            rd(ad(p, `PFP_OFF_DCNT), {16'h0000, dc[i]}, 1'b0);
        end
        apb(1'b1, ad(3'h3, `PFP_OFF_DCNT), 32'h0000_0001);
        rd(ad(3'h3, `PFP_OFF_DCNT), 32'h0, 1'b0);
        $display("test random frames done");
        stop_test;
    end
endmodule // tb
bind pfp_policy pfp_policy_chk pfp_policy_chk_i (.REF_CLK_I, .SRST_I,
    .PSEL_I, .PENABLE_I, .PREADY_O, .FRM_VALID_I, .FRM_PORT_I,
    .FRM_TAGGED_I, .FRM_VID_I, .FRM_PRIO_I, .FRM_DST_I, .CONG_I, .VLT_REQ_O,
    .VLT_VID_O, .RES_VALID_O, .RES_DISCARD_O, .RES_FWD_O, .RES_REASON_O,
    .FC_O);
